// ===== hdl/fsr2_regs.sv
// second status register: secure area locks, quad enable, upper guard
//
// Functional notes
// - lock flag sets on last secure byte programmed
// - flags three/two/one at bits 5/4/3
// - flags reset to zero, host read-only
// - locked secure area refuses further programming
// - secure area zero always locked, no flag
// - bit 2 reserved, reads zero
// - bit 1 quad enable, read/write, reset 0
// - quad off: protect and hold pins normal
// - quad on: pins are data lines two, three
// - quad gates 6B, EB, E7 commands
// - quad gates 32, 77, 94 commands
// - bit 0 upper guard, read/write, reset 0
// - guard bits pick soft/hard/otp/reset lock
// - upper guard held as a volatile bit; lower guard comes in on guard_lower_in
// - both guards zero: write with latch set
// - upper 0, lower 1, pin low, quad off: refuse
`timescale 1ns/1ps
module fsr2_regs
  import fsr2_pkg::*;
(
  input  wire logic                   core_clk_in,       // 100 MHz clock
  input  wire logic                   rst_n_in,          // async reset
  input  wire logic                   stat_wr_in,        // write status strobe
  input  wire logic [fsr2_pkg::STAT_W-1:0] stat_wdata_in, // write data
  input  wire logic                   write_latch_flag_in, // write enable latch
  input  wire logic                   guard_lower_in,    // lower guard bit
  input  wire logic                   guard_lower_wr_in, // lower guard new
  input  wire logic                   status_guard_permanent_in, // otp lock
  input  wire logic                   sec_prog_in,       // secure byte program
  input  wire logic [1:0]             sec_area_in,       // secure area 0..3
  input  wire logic [fsr2_pkg::AREA_ADDR_W-1:0] sec_byte_in, // byte in area
  input  wire logic [7:0]             cmd_in,            // decoded opcode
  input  wire logic                   cmd_valid_in,      // opcode strobe
  input  wire logic                   wp_pin_in,         // protect pin level
  input  wire logic                   hold_pin_in,       // hold/reset level
  output logic [fsr2_pkg::STAT_W-1:0] stat_rdata_out,    // register readback
  output logic                        quad_lines_enable_out, // quad mode
  output logic                        status_wr_ok_out,  // writes allowed
  output logic                        stat_wr_done_out,  // write applied
  output logic                        stat_wr_refused_out, // write refused
  output logic                        sec_prog_ok_out,   // program allowed
  output logic                        sec_prog_refused_out, // program refused
  output logic                        cmd_allowed_out,   // opcode permitted
  output logic                        cmd_refused_out,   // opcode refused
  output logic                        wp_active_out,     // pin protect live
  output logic                        hold_active_out    // hold function live
);
  import fsr2_pkg::*;

  logic [2:0] secure_area_lock_flags_q;
  logic       quad_lines_enable_q;
  logic       status_guard_upper_q;
  logic       wr_go;
  logic       last_byte;
  logic       area_locked;
  logic       wr_try;

  fsr2_guard_if gi ();
  fsr2_guard u_guard (.g(gi));

  assign gi.guard_upper = status_guard_upper_q;
  assign gi.guard_lower = guard_lower_in;
  assign gi.guard_permanent = status_guard_permanent_in;
  assign gi.wp_level = wp_pin_in;
  assign gi.quad_en = quad_lines_enable_q;

  function automatic logic quad_cmd(input logic [7:0] op);
    quad_cmd = (op == CMD_QUAD_OUT_READ) || (op == CMD_XIP_READ) ||
               (op == CMD_XIP_READ_DW) || (op == CMD_QUAD_PAGE_PROG) ||
               (op == CMD_BURST_WRAP) || (op == CMD_QUAD_ID_READ);
  endfunction : quad_cmd

  function automatic logic lock_of(input logic [2:0] f,
                                   input logic [1:0] a);
    unique case (a)
      2'd0: lock_of = 1'b1;
      2'd1: lock_of = f[0];
      2'd2: lock_of = f[1];
      2'd3: lock_of = f[2];
    endcase
  endfunction : lock_of

  // one-hot set mask; area zero has no flag, so nothing to set
  function automatic logic [2:0] lock_req(input logic [1:0] a);
    unique case (a)
      2'd0: lock_req = 3'h0;
      2'd1: lock_req = 3'h1;
      2'd2: lock_req = 3'h2;
      2'd3: lock_req = 3'h4;
    endcase
  endfunction : lock_req

  assign wr_try = stat_wr_in & write_latch_flag_in;
  assign wr_go = wr_try & gi.status_wr_ok;
  assign area_locked = lock_of(secure_area_lock_flags_q, sec_area_in);
  assign last_byte = sec_byte_in == AREA_LAST_BYTE;

  // set-only flags: nothing but reset clears them
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      secure_area_lock_flags_q <= LOCK_RESET;
    end else if (sec_prog_in && !area_locked && last_byte) begin
      secure_area_lock_flags_q <= secure_area_lock_flags_q |
                                  lock_req(sec_area_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quad_lines_enable_q <= QUAD_RESET;
    end else if (wr_go) begin
      quad_lines_enable_q <= stat_wdata_in[QUAD_POS];
    end
  end

  // upper guard is volatile only; reset clears it, but the lower guard and pin still decide writes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_guard_upper_q <= GUARD_UP_RESET;
    end else if (wr_go) begin
      status_guard_upper_q <= stat_wdata_in[GUARD_UP_POS];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_rdata_out <= '0;
    end else begin
      stat_rdata_out <= '0;
      stat_rdata_out[LOCK_HI_POS:LOCK_LO_POS] <= secure_area_lock_flags_q;
      stat_rdata_out[QUAD_POS] <= quad_lines_enable_q;
      stat_rdata_out[GUARD_UP_POS] <= status_guard_upper_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_wr_done_out <= 1'b0;
    end else begin
      stat_wr_done_out <= wr_go;
    end
  end

  // no latch means a silent drop, not a refusal
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stat_wr_refused_out <= 1'b0;
    end else begin
      stat_wr_refused_out <= wr_try & ~gi.status_wr_ok;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_wr_ok_out <= 1'b0;
    end else begin
      status_wr_ok_out <= gi.status_wr_ok;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_prog_ok_out <= 1'b0;
    end else begin
      sec_prog_ok_out <= sec_prog_in & ~area_locked;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_prog_refused_out <= 1'b0;
    end else begin
      sec_prog_refused_out <= sec_prog_in & area_locked;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_allowed_out <= 1'b0;
    end else begin
      cmd_allowed_out <= cmd_valid_in &
                         (~quad_cmd(cmd_in) | quad_lines_enable_q);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_refused_out <= 1'b0;
    end else begin
      cmd_refused_out <= cmd_valid_in & quad_cmd(cmd_in) &
                         ~quad_lines_enable_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quad_lines_enable_out <= QUAD_RESET;
    end else begin
      quad_lines_enable_out <= quad_lines_enable_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_active_out <= 1'b0;
    end else begin
      wp_active_out <= ~quad_lines_enable_q & ~wp_pin_in;
    end
  end

  // in quad mode the hold pin carries data, so its level means nothing
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_active_out <= 1'b0;
    end else begin
      hold_active_out <= ~quad_lines_enable_q & ~hold_pin_in;
    end
  end

  logic unused_ok;
  assign unused_ok = guard_lower_wr_in;
endmodule : fsr2_regs

// ===== shared/fsr2_pkg.sv
// constants and types for the second status register block
package fsr2_pkg;
  localparam int STAT_W = 8;
  localparam int LOCK_HI_POS = 5;
  localparam int LOCK_MID_POS = 4;
  localparam int LOCK_LO_POS = 3;
  localparam int RSVD_POS = 2;
  localparam int QUAD_POS = 1;
  localparam int GUARD_UP_POS = 0;
  localparam int AREA_BYTES = 128;
  localparam int AREA_ADDR_W = 7;
  localparam logic [AREA_ADDR_W-1:0] AREA_LAST_BYTE = 7'h7F;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic QUAD_RESET = 1'b0;
  localparam logic GUARD_UP_RESET = 1'b0;
  localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] CMD_XIP_READ = 8'hEB;
  localparam logic [7:0] CMD_XIP_READ_DW = 8'hE7;
  localparam logic [7:0] CMD_QUAD_PAGE_PROG = 8'h32;
  localparam logic [7:0] CMD_BURST_WRAP = 8'h77;
  localparam logic [7:0] CMD_QUAD_ID_READ = 8'h94;
  localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;

  typedef enum logic [1:0] {
    FSR2_SOFT_PROT = 2'b00,
    FSR2_HARD_PROT = 2'b01,
    FSR2_RESET_LOCK = 2'b11,
    FSR2_OTP_LOCK = 2'b10
  } fsr2_prot_t;
endpackage : fsr2_pkg

// ===== shared/fsr2_guard_if.sv
// protection decision passed from guard logic to the register top
`timescale 1ns/1ps
interface fsr2_guard_if;
  import fsr2_pkg::*;
  logic       guard_upper;
  logic       guard_lower;
  logic       guard_permanent;
  logic       wp_level;
  logic       quad_en;
  fsr2_prot_t prot_mode;
  logic       status_wr_ok;
  modport top (output guard_upper, guard_lower, guard_permanent, wp_level,
               quad_en, input prot_mode, status_wr_ok);
  modport guard (input guard_upper, guard_lower, guard_permanent, wp_level,
                 quad_en, output prot_mode, status_wr_ok);
endinterface : fsr2_guard_if

// ===== hdl/fsr2_guard.sv
// status register write protection decode
`timescale 1ns/1ps
module fsr2_guard
  import fsr2_pkg::*;
(
  fsr2_guard_if.guard g  // protect bits in, decision out
);
  always_comb begin
    unique case ({g.guard_upper, g.guard_lower})
      2'b00: g.prot_mode = FSR2_SOFT_PROT;
      2'b01: g.prot_mode = FSR2_HARD_PROT;
      2'b10: g.prot_mode = FSR2_RESET_LOCK;
      2'b11: g.prot_mode = g.guard_permanent ? FSR2_OTP_LOCK
                                             : FSR2_RESET_LOCK;
    endcase
  end

  always_comb begin
    unique case (g.prot_mode)
      FSR2_SOFT_PROT: g.status_wr_ok = 1'b1;
      // pin counts only when it is not a data line
      FSR2_HARD_PROT: g.status_wr_ok = g.quad_en | g.wp_level;
      FSR2_RESET_LOCK: g.status_wr_ok = 1'b0;
      FSR2_OTP_LOCK: g.status_wr_ok = 1'b0;
    endcase
  end
endmodule : fsr2_guard

// ===== tb/fsr2_monitor.sv
// concurrent checks on the second status register ports
`timescale 1ns/1ps
module fsr2_monitor
  import fsr2_pkg::*;
(
  input wire logic               core_clk_in,           // clock
  input wire logic               rst_n_in,              // reset
  input wire logic               stat_wr_in,            // write
  input wire logic [STAT_W-1:0]  stat_wdata_in,         // data
  input wire logic               write_latch_flag_in,   // latch
  input wire logic               guard_lower_in,        // guard
  input wire logic               wp_pin_in,             // pin
  input wire logic               sec_prog_in,           // program
  input wire logic [1:0]         sec_area_in,           // area
  input wire logic [AREA_ADDR_W-1:0] sec_byte_in,       // byte
  input wire logic [7:0]         cmd_in,                // opcode
  input wire logic               cmd_valid_in,          // strobe
  input wire logic [STAT_W-1:0]  stat_rdata_out,        // readback
  input wire logic               quad_lines_enable_out, // quad
  input wire logic               stat_wr_done_out,      // done
  input wire logic               stat_wr_refused_out,   // refused
  input wire logic               sec_prog_refused_out,  // refused
  input wire logic               cmd_refused_out,       // refused
  input wire logic               wp_active_out,         // pin live
  input wire logic               hold_active_out        // pin live
);
  logic q_op;
  assign q_op = cmd_in inside {CMD_QUAD_OUT_READ, CMD_XIP_READ,
    CMD_XIP_READ_DW, CMD_QUAD_PAGE_PROG, CMD_BURST_WRAP, CMD_QUAD_ID_READ};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  rsvd_zero_a: assert property (stat_rdata_out[7:6] == 2'h0
    && !stat_rdata_out[2]) else $error("reserved bit not zero");
  quad_mirror_a: assert property (stat_rdata_out[1] ==
    quad_lines_enable_out) else $error("quad readback differs");
  pins_data_a: assert property (quad_lines_enable_out &&
    $past(quad_lines_enable_out) |-> !wp_active_out && !hold_active_out)
    else $error("pin function live in quad mode");
  quad_gate_a: assert property (cmd_valid_in && q_op &&
    !quad_lines_enable_out && !$past(stat_wr_in) |=> cmd_refused_out)
    else $error("quad opcode not refused");
  area_zero_a: assert property (sec_prog_in && sec_area_in == 2'h0
    |=> sec_prog_refused_out) else $error("area zero programmed");
  lock_set_a: assert property (sec_prog_in && sec_area_in != 2'h0 &&
    sec_byte_in == AREA_LAST_BYTE |-> ##2
    stat_rdata_out[$past(sec_area_in, 2) + 2]) else $error("lock not set");
  lock_hold_a: assert property (($past(stat_rdata_out[5:3]) &
    ~stat_rdata_out[5:3]) == 3'h0) else $error("lock flag cleared");
  hard_refuse_a: assert property (stat_wr_in && write_latch_flag_in &&
    guard_lower_in && !stat_rdata_out[0] && !wp_pin_in &&
    !quad_lines_enable_out && !$past(stat_wr_in) |=> stat_wr_refused_out)
    else $error("protected write not refused");
  soft_write_a: assert property (stat_wr_in && write_latch_flag_in &&
    !guard_lower_in && !stat_rdata_out[0] && !$past(stat_wr_in) |=>
    stat_wr_done_out ##1 stat_rdata_out[1:0] == $past(stat_wdata_in[1:0], 2))
    else $error("open write not applied");
endmodule : fsr2_monitor

// ===== tb/fsr2_host.sv
// host model issuing status writes, secure programs and opcodes
`timescale 1ns/1ps
module fsr2_host (
  input  wire logic       core_clk_in, // clock
  output logic            wr_out,      // status write strobe
  output logic [7:0]      wd_out,      // write data
  output logic            wel_out,     // write latch
  output logic            pg_out,      // secure program strobe
  output logic [1:0]      ar_out,      // secure area
  output logic [6:0]      by_out,      // secure byte
  output logic [7:0]      op_out,      // opcode
  output logic            ov_out       // opcode strobe
);
  initial begin
    {wr_out, wd_out, pg_out, ar_out, by_out, op_out, ov_out} = '0;
    wel_out = 1'b1;
  end
  // kind 0 status write, 1 secure program, 2 opcode; one cycle strobe
  task automatic go(input int k, input logic [7:0] v, input logic [6:0] b);
    @(posedge core_clk_in);
    wr_out <= (k == 0);
    pg_out <= (k == 1);
    ov_out <= (k == 2);
    {wd_out, op_out} <= {v, v};
    ar_out <= v[1:0];
    by_out <= b;
    @(posedge core_clk_in);
    {wr_out, pg_out, ov_out} <= 3'h0;
    {wd_out, op_out} <= {~v, ~v};
  endtask : go
endmodule : fsr2_host

// ===== tb/test_flash_status_reg2_fields.sv
// self-checking bench for the second status register
`timescale 1ns/1ps
module test_flash_status_reg2_fields;
  import fsr2_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       g_lo = 1'b0;
  logic       wp = 1'b0;
  logic       perm = 1'b0;
  logic       hold = 1'b0;
  logic       wr, write_latch_flag, pg, ov;
  logic [7:0] wd, op;
  logic [1:0] ar;
  logic [6:0] by;
  int         n_errors = 0;
  int         num_checks = 0;
  logic [7:0] qop [6] = '{CMD_QUAD_OUT_READ, CMD_XIP_READ, CMD_XIP_READ_DW,
    CMD_QUAD_PAGE_PROG, CMD_BURST_WRAP, CMD_QUAD_ID_READ};
  always #5 clk = ~clk;
  fsr2_host host_u (.core_clk_in(clk), .wr_out(wr), .wd_out(wd),
    .wel_out(write_latch_flag), .pg_out(pg), .ar_out(ar), .by_out(by), .op_out(op),
    .ov_out(ov));
  fsr2_regs dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .stat_wr_in(wr),
    .stat_wdata_in(wd), .write_latch_flag_in(write_latch_flag), .guard_lower_in(g_lo),
    .guard_lower_wr_in(1'b0), .status_guard_permanent_in(perm),
    .sec_prog_in(pg), .sec_area_in(ar), .sec_byte_in(by), .cmd_in(op),
    .cmd_valid_in(ov), .wp_pin_in(wp), .hold_pin_in(hold),
    .stat_rdata_out(), .quad_lines_enable_out(), .status_wr_ok_out(),
    .stat_wr_done_out(), .stat_wr_refused_out(), .sec_prog_ok_out(),
    .sec_prog_refused_out(), .cmd_allowed_out(), .cmd_refused_out(),
    .wp_active_out(), .hold_active_out());
  task automatic ck(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : ck
  task automatic rb(input logic [7:0] e);
    @(posedge clk);
    #1 ck(dut_u.stat_rdata_out, e);
  endtask : rb
  task automatic pins(input logic g, input logic w);
    @(posedge clk);
    g_lo <= g;
    wp <= w;
  endtask : pins
  task automatic close_out;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rb(8'h00);
    for (int m = 0; m < 2; m++) begin
      host_u.go(0, m ? 8'h00 : 8'hFE, 7'h00);
      #1 ck(dut_u.stat_wr_done_out, 8'h01);
      ck(dut_u.status_wr_ok_out, 8'h01);
      rb(m ? 8'h00 : 8'h02);
      ck({dut_u.wp_active_out, dut_u.hold_active_out}, 8'(m * 3));
      foreach (qop[i]) begin
        host_u.go(2, qop[i], 7'h00);
        #1 ck({dut_u.cmd_allowed_out,
               dut_u.cmd_refused_out}, 8'(2 - m));
      end
    end
    @(posedge clk);
    hold <= 1'b1;
    rb(8'h00);
    ck({dut_u.wp_active_out, dut_u.hold_active_out}, 8'h02);
    pins(1'b1, 1'b0);
    host_u.go(0, 8'h03, 7'h00);
    #1 ck(dut_u.stat_wr_refused_out, 8'h01);
    ck(dut_u.status_wr_ok_out, 8'h00);
    pins(1'b1, 1'b1);
    host_u.go(0, 8'h01, 7'h00);
    #1 ck(dut_u.stat_wr_done_out, 8'h01);
    rb(8'h01);
    pins(1'b0, 1'b1);
    host_u.go(0, 8'h00, 7'h00);
    #1 ck(dut_u.stat_wr_refused_out, 8'h01);
    pins(1'b1, 1'b1);
    perm <= 1'b1;
    host_u.go(0, 8'h00, 7'h00);
    #1 ck(dut_u.stat_wr_refused_out, 8'h01);
    ck(dut_u.status_wr_ok_out, 8'h00);
    host_u.go(1, 8'h01, 7'h7E);
    #1 ck(dut_u.sec_prog_ok_out, 8'h01);
    rb(8'h01);
    for (int a = 1; a < 4; a++) host_u.go(1, 8'(a), 7'h7F);
    rb(8'h39);
    for (int a = 0; a < 2; a++) begin
      host_u.go(1, 8'(a), 7'h00);
      #1 ck(dut_u.sec_prog_refused_out, 8'h01);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rb(8'h00);
    close_out;
  end
endmodule : test_flash_status_reg2_fields
bind fsr2_regs fsr2_monitor mon_u (.core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in), .stat_wr_in(stat_wr_in), .stat_wdata_in(stat_wdata_in),
  .write_latch_flag_in(write_latch_flag_in), .guard_lower_in(guard_lower_in),
  .wp_pin_in(wp_pin_in), .sec_prog_in(sec_prog_in), .sec_area_in(sec_area_in),
  .sec_byte_in(sec_byte_in), .cmd_in(cmd_in), .cmd_valid_in(cmd_valid_in),
  .stat_rdata_out(stat_rdata_out),
  .quad_lines_enable_out(quad_lines_enable_out),
  .stat_wr_done_out(stat_wr_done_out), .wp_active_out(wp_active_out),
  .stat_wr_refused_out(stat_wr_refused_out), .cmd_refused_out(cmd_refused_out),
  .sec_prog_refused_out(sec_prog_refused_out),
  .hold_active_out(hold_active_out));
